// ==== logic/mbp_bus_port.sv ====
// What this block does
// (RULE1) attach 8-bit hosts, muxed or separate buses; controls feed logic
// (RULE2) latch address from both ports on the address latch strobe
// (RULE3) alternate strobe option latches address on its rising edge
// (RULE4) drive data only during read with an internal block selected
// (RULE5) host wires low byte or burst bits to the lower port
// (RULE6) host wires upper address or byte to the upper port
// (RULE7) first control is write strobe or read/write direction
// (RULE8) second control is read, E clock, data strobe or fetch
// (RULE9) third control is fetch select, else a generic logic input
// (RULE10) reset clears ports, cells, some config; held at power-up
// (RULE11) reset aborts a running flash program or erase cycle
// (RULE12) chip select low enables memories, high disables them
// (RULE13) chip select trailing edge wakes the device from power-down
// (RULE14) optional clock pin drives cells, power-down counter, array
// (RULE15) auto power-down turns functions off on host inactivity
// (RULE16) turbo off latches logic outputs until an input moves
// (RULE17) blocking bits keep chosen inputs from the logic array
// (RULE18) 8-bit page register adds address bits for decoding
// (RULE19) port F as data bus or low address inputs in burst mode
// (RULE20) port C pins as host I/O, logic inputs or chip selects
// (RULE21) port E 0..5 carry serial programming pins, muxed
// (RULE22) port E bit 7 high while running from backup battery
// assumes pins arrive asynchronous; array outputs come from outside
`timescale 1ns/100ps
`default_nettype none
module mbp_bus_port
#(
  parameter int unsigned APD_CYCLES = mbp_pkg::APD_IDLE_CYC
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // configuration
  input wire mbp_pkg::mbp_bus_mode_t busMode,
  input wire mbp_pkg::mbp_ctl0_mode_t ctl0Mode,
  input wire mbp_pkg::mbp_ctl1_mode_t ctl1Mode,
  input wire logic ctl2IsFetch,
  input wire logic altStrobeEn,
  input wire logic chipSelEn,
  input wire logic clkInEn,
  input wire logic [7:0] portCMode,
  input wire logic [7:0] portCDir,
  input wire logic [7:0] portCOut,
  input wire logic progPortEn,
  // host pins
  input wire logic [7:0] lowerAdIn,
  output logic [7:0] lowerAdOut,
  output logic [7:0] lowerAdOe,
  input wire logic [7:0] upperAdIn,
  input wire logic [7:0] portFIn,
  output logic [7:0] portFOut,
  output logic [7:0] portFOe,
  input wire logic addrStrobe,
  input wire logic ctl0,
  input wire logic ctl1,
  input wire logic ctl2,
  input wire logic chipSel_n,
  input wire logic logicClkIn,
  // host writes to internal registers
  input wire logic pageWr,
  input wire logic pwr0Wr,
  input wire logic pwr2Wr,
  // internal side
  input wire logic blockSel,
  input wire logic [7:0] readData,
  input wire logic progBusy,
  input wire logic onBattery,
  input wire logic [7:0] arrayCs,
  input wire logic [5:0] serialOut,
  output logic [19:0] latchedAddr,
  output logic [7:0] pageReg,
  output logic [7:0] writeData,
  output logic writeStb,
  output logic memEnable,
  output logic powerDown,
  output logic progAbort,
  output logic arrayClkEn,
  output logic arrayHold,
  output logic [4:0] arrayCtlIn,
  // port C and E pins
  input wire logic [7:0] portCIn,
  output logic [7:0] portCOutPin,
  output logic [7:0] portCOe,
  output logic [7:0] portCArrayIn,
  input wire logic [5:0] portEIn,
  output logic [5:0] serialIn,
  output logic [7:0] portEOut,
  output logic [7:0] portEOe
);
  // elaboration check: the idle counter needs room to count
  if (APD_CYCLES < 2)
    $error("APD_CYCLES too small");
  //////////////////////////////////////////////////////////////////////
  // two-stage synchronisers on every pin
  localparam int unsigned NSY = 46;
  // strobes and selects reset to their idle levels: no false edge
  localparam logic [NSY-1:0] SY_IDLE = 46'h78;
  logic [NSY-1:0] syA_q, syB_q, syRaw;
  assign syRaw = {portEIn, portCIn, portFIn, upperAdIn, lowerAdIn,
    addrStrobe, ctl0, ctl1, ctl2, chipSel_n, logicClkIn, 2'b00};
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syA_q <= SY_IDLE;
      syB_q <= SY_IDLE;
    end
    else
    begin
      syA_q <= syRaw;
      syB_q <= syA_q;
    end
  end
  logic [5:0] sEIn;
  logic [7:0] sCIn, sFIn, sUp, sLo;
  logic sAs, sC0, sC1, sC2, sCs_n, sClk;
  assign {sEIn, sCIn, sFIn, sUp, sLo, sAs, sC0, sC1, sC2, sCs_n, sClk}
    = syB_q[NSY-1:2];
  //////////////////////////////////////////////////////////////////////
  // control decode
  mbp_strobe_if stb ();
  mbp_ctl_decode u_dec
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ctl0Mode(ctl0Mode),
    .ctl1Mode(ctl1Mode),
    .ctl2IsFetch(ctl2IsFetch),
    .ctl0(sC0),
    .ctl1(sC1),
    .ctl2(sC2),
    .stb(stb)
  );
  //////////////////////////////////////////////////////////////////////
  // address latch, page, power registers, outputs
  logic asPrev_q, asPrev_d, csPrev_q, csPrev_d, clkPrev_q, clkPrev_d;
  logic [19:0] addr_q, addr_d;
  logic [7:0] page_q, page_d, pwr0_q, pwr0_d, pwr2_q, pwr2_d;
  logic [7:0] loOut_q, loOut_d, loOe_q, loOe_d;
  logic [7:0] fOut_q, fOut_d, fOe_q, fOe_d;
  logic [7:0] wdat_q, wdat_d;
  logic wstb_q, wstb_d, wrPrev_q, wrPrev_d;
  logic latch;
  logic [7:0] dataIn;
  always_comb
  begin
    asPrev_d = sAs;
    csPrev_d = sCs_n;
    clkPrev_d = sClk;
    wrPrev_d = stb.wrStb;
    // plain latch strobe is high-active; alternate form samples rising
    latch = altStrobeEn ? (sAs & ~asPrev_q) : sAs; // [RULE2] [RULE3]
    dataIn = (busMode == mbp_pkg::BUS_MUX) ? sLo : sFIn; // [RULE1] [RULE19]
    addr_d = addr_q;
    if (latch)
    begin
      unique case (busMode) // [RULE5] [RULE6]
        mbp_pkg::BUS_BURST:
          addr_d = {sUp, sLo, sFIn[3:0]}; // [RULE19]
        default:
          addr_d = {4'h0, sUp, sLo};
      endcase
    end
    page_d = pageWr & stb.wrStb ? dataIn : page_q; // [RULE18]
    pwr0_d = pwr0Wr & stb.wrStb ? dataIn : pwr0_q;
    pwr2_d = pwr2Wr & stb.wrStb ? dataIn : pwr2_q; // [RULE17]
    wdat_d = stb.wrStb ? dataIn : wdat_q;
    wstb_d = stb.wrStb & ~wrPrev_q;
    loOut_d = readData;
    fOut_d = readData;
    // drive only while a read hits a selected block
    loOe_d = {8{(stb.rdStb | stb.fetchStb) & blockSel & memEnable
      & busMode == mbp_pkg::BUS_MUX}}; // [RULE4]
    fOe_d = {8{(stb.rdStb | stb.fetchStb) & blockSel & memEnable
      & busMode != mbp_pkg::BUS_MUX}}; // [RULE4] [RULE19]
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n) // [RULE10]
    begin
      asPrev_q <= 1'b0;
      csPrev_q <= 1'b1;
      clkPrev_q <= 1'b0;
      wrPrev_q <= 1'b0;
      addr_q <= '0;
      page_q <= mbp_pkg::PAGE_RST;
      pwr0_q <= mbp_pkg::PWR0_RST;
      pwr2_q <= mbp_pkg::PWR2_RST;
      wdat_q <= 8'h00;
      wstb_q <= 1'b0;
      loOut_q <= 8'h00;
      loOe_q <= 8'h00;
      fOut_q <= 8'h00;
      fOe_q <= 8'h00;
    end
    else
    begin
      asPrev_q <= asPrev_d;
      csPrev_q <= csPrev_d;
      clkPrev_q <= clkPrev_d;
      wrPrev_q <= wrPrev_d;
      addr_q <= addr_d;
      page_q <= page_d;
      pwr0_q <= pwr0_d;
      pwr2_q <= pwr2_d;
      wdat_q <= wdat_d;
      wstb_q <= wstb_d;
      loOut_q <= loOut_d;
      loOe_q <= loOe_d;
      fOut_q <= fOut_d;
      fOe_q <= fOe_d;
    end
  end
  assign latchedAddr = addr_q;
  assign pageReg = page_q;
  assign writeData = wdat_q;
  assign writeStb = wstb_q;
  assign lowerAdOut = loOut_q;
  assign lowerAdOe = loOe_q;
  assign portFOut = fOut_q;
  assign portFOe = fOe_q;
  //////////////////////////////////////////////////////////////////////
  // power management: auto power-down, chip select, turbo hold
  typedef enum logic [1:0] {
    PM_RUN = 2'b01,
    PM_DOWN = 2'b10
  } mbp_pm_t;
  mbp_pm_t pm_q, pm_d;
  logic [$clog2(APD_CYCLES+1)-1:0] idle_q, idle_d;
  logic memEn_q, memEn_d, hold_q, hold_d, clkEn_q, clkEn_d;
  logic abort_q, abort_d;
  logic [4:0] actl_q, actl_d;
  logic csTrail, clkTick, inMove;
  always_comb
  begin
    csTrail = chipSelEn & sCs_n & ~csPrev_q; // [RULE13]
    // counter advances on the logic clock pin when that is enabled
    clkTick = clkInEn ? (sClk & ~clkPrev_q) : 1'b1; // [RULE14]
    inMove = stb.active | latch | csTrail;
    idle_d = idle_q;
    pm_d = pm_q;
    unique case (pm_q)
      PM_RUN:
      begin
        if (inMove)
          idle_d = '0;
        else if (clkTick && idle_q != APD_CYCLES[$bits(idle_q)-1:0])
          idle_d = idle_q + 1'b1;
        if (pwr0_q[mbp_pkg::PWR0_APD_EN] && !inMove
          && idle_q == APD_CYCLES[$bits(idle_q)-1:0])
          pm_d = PM_DOWN; // [RULE15]
      end
      PM_DOWN:
      begin
        idle_d = '0;
        if (csTrail || stb.active || !pwr0_q[mbp_pkg::PWR0_APD_EN])
          pm_d = PM_RUN; // [RULE13]
      end
      default:
        pm_d = PM_RUN;
    endcase
    memEn_d = (chipSelEn ? ~sCs_n : 1'b1) & (pm_d == PM_RUN); // [RULE12]
    // hold until a control strobe edge, address latch or chip select trailing edge, released while one is seen
    hold_d = pwr0_q[mbp_pkg::PWR0_TURBO_OFF] & ~inMove; // [RULE16]
    clkEn_d = clkInEn & ~pwr0_q[mbp_pkg::PWR0_CLK_MCELL_OFF]
      & ~pwr0_q[mbp_pkg::PWR0_CLK_ARRAY_OFF]; // [RULE14]
    actl_d = {sClk & clkInEn & ~pwr0_q[mbp_pkg::PWR0_CLK_ARRAY_OFF],
      sC2 & ~pwr2_q[mbp_pkg::PWR2_CTL2_BLK],
      sC1 & ~pwr2_q[mbp_pkg::PWR2_CTL1_BLK],
      sC0 & ~pwr2_q[mbp_pkg::PWR2_CTL0_BLK],
      sAs & ~pwr2_q[mbp_pkg::PWR2_ALE_BLK]}; // [RULE17] [RULE1]
    abort_d = progBusy & ~rst_n;
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pm_q <= PM_RUN;
      idle_q <= '0;
      memEn_q <= 1'b0;
      hold_q <= 1'b0;
      clkEn_q <= 1'b0;
      actl_q <= 5'h00;
      abort_q <= 1'b1; // [RULE11]
    end
    else
    begin
      pm_q <= pm_d;
      idle_q <= idle_d;
      memEn_q <= memEn_d;
      hold_q <= hold_d;
      clkEn_q <= clkEn_d;
      actl_q <= actl_d;
      abort_q <= abort_d;
    end
  end
  assign memEnable = memEn_q;
  // one-hot: the down bit is the flag itself
  assign powerDown = pm_q[1];
  assign arrayHold = hold_q;
  assign arrayClkEn = clkEn_q;
  assign arrayCtlIn = actl_q;
  assign progAbort = abort_q;
  //////////////////////////////////////////////////////////////////////
  // port C and port E pin functions
  logic [7:0] cOut_q, cOut_d, cOe_q, cOe_d, cArr_q, cArr_d;
  logic [7:0] eOut_q, eOut_d, eOe_q, eOe_d;
  logic [5:0] ser_q, ser_d;
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      // mode bit set: pin is an external chip select output
      cOut_d[i] = portCMode[i] ? arrayCs[i] : portCOut[i]; // [RULE20]
      cOe_d[i] = portCMode[i] | portCDir[i]; // [RULE20]
      cArr_d[i] = sCIn[i] & ~portCMode[i] & ~portCDir[i]; // [RULE20]
    end
    ser_d = progPortEn ? sEIn : 6'h00; // [RULE21]
    // only data out, status and error are outputs of the serial port
    eOut_d = {onBattery, 1'b0, serialOut[5:3], 3'h0}; // [RULE22] [RULE21]
    eOe_d = {1'b1, 1'b0, {3{progPortEn}}, 3'h0}; // [RULE22] [RULE21]
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cOut_q <= 8'h00;
      cOe_q <= 8'h00;
      cArr_q <= 8'h00;
      eOut_q <= 8'h00;
      eOe_q <= 8'h00;
      ser_q <= 6'h00;
    end
    else
    begin
      cOut_q <= cOut_d;
      cOe_q <= cOe_d;
      cArr_q <= cArr_d;
      eOut_q <= eOut_d;
      eOe_q <= eOe_d;
      ser_q <= ser_d;
    end
  end
  assign portCOutPin = cOut_q;
  assign portCOe = cOe_q;
  assign portCArrayIn = cArr_q;
  assign portEOut = eOut_q;
  assign portEOe = eOe_q;
  assign serialIn = ser_q;
endmodule : mbp_bus_port
`default_nettype wire

// ==== logic/mbp_ctl_decode.sv ====
// decodes the three host control inputs into read, write and fetch
// assumes inputs already synchronised to sys_clk
`timescale 1ns/100ps
`default_nettype none
module mbp_ctl_decode
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // configuration
  input wire mbp_pkg::mbp_ctl0_mode_t ctl0Mode,
  input wire mbp_pkg::mbp_ctl1_mode_t ctl1Mode,
  input wire logic ctl2IsFetch,
  // synchronised pins
  input wire logic ctl0,
  input wire logic ctl1,
  input wire logic ctl2,
  // decoded strobes
  mbp_strobe_if.src stb
);
  logic rd, wr, fe, eDel_q, eDel_d;
  always_comb
  begin
    rd = 1'b0;
    wr = 1'b0;
    fe = ctl2IsFetch & ~ctl2; // [RULE9]
    unique case (ctl1Mode) // [RULE8]
      mbp_pkg::CTL1_READ_N, mbp_pkg::CTL1_FETCH_N:
      begin
        rd = ~ctl1;
        wr = (ctl0Mode == mbp_pkg::CTL0_WRITE_N) & ~ctl0;
      end
      mbp_pkg::CTL1_ECLK, mbp_pkg::CTL1_DSTROBE_N:
      begin
        // direction line qualified by the strobe
        rd = (ctl1Mode == mbp_pkg::CTL1_ECLK ? ctl1 : ~ctl1)
          & (ctl0Mode == mbp_pkg::CTL0_RW ? ctl0 : 1'b1); // [RULE7]
        wr = (ctl1Mode == mbp_pkg::CTL1_ECLK ? ctl1 : ~ctl1)
          & (ctl0Mode == mbp_pkg::CTL0_RW ? ~ctl0 : ~ctl0); // [RULE7]
      end
    endcase
    if (ctl1Mode == mbp_pkg::CTL1_FETCH_N)
      fe = ~ctl1;
    eDel_d = rd | wr | fe;
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      eDel_q <= 1'b0;
    else
      eDel_q <= eDel_d;
  end
  assign stb.rdStb = rd;
  assign stb.wrStb = wr;
  assign stb.fetchStb = fe;
  // activity seen on any edge of the combined strobe
  assign stb.active = eDel_d ^ eDel_q;
endmodule : mbp_ctl_decode
`default_nettype wire

// ==== logic/mbp_pkg.sv ====
// shared constants and types for the host bus port block
// assumes a single 50 MHz system clock domain
package mbp_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned APD_IDLE_US = 100;
  localparam int unsigned APD_IDLE_CYC = APD_IDLE_US * CLK_MHZ;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] PWR0_RST = 8'h00;
  localparam logic [7:0] PWR2_RST = 8'h00;
  // power control 0 fields
  localparam int unsigned PWR0_APD_EN = 1;
  localparam int unsigned PWR0_TURBO_OFF = 3;
  localparam int unsigned PWR0_CLK_ARRAY_OFF = 4;
  localparam int unsigned PWR0_CLK_MCELL_OFF = 5;
  // power control 2 fields
  localparam int unsigned PWR2_ADDR_BLK = 0;
  localparam int unsigned PWR2_CTL0_BLK = 2;
  localparam int unsigned PWR2_CTL1_BLK = 3;
  localparam int unsigned PWR2_CTL2_BLK = 4;
  localparam int unsigned PWR2_ALE_BLK = 5;
  // first control input meaning
  typedef enum logic [0:0] {
    CTL0_WRITE_N = 1'b0,
    CTL0_RW = 1'b1
  } mbp_ctl0_mode_t;
  // second control input meaning
  typedef enum logic [1:0] {
    CTL1_READ_N = 2'h0,
    CTL1_ECLK = 2'h1,
    CTL1_DSTROBE_N = 2'h2,
    CTL1_FETCH_N = 2'h3
  } mbp_ctl1_mode_t;
  // address bus shape
  typedef enum logic [1:0] {
    BUS_MUX = 2'h0,
    BUS_NONMUX = 2'h1,
    BUS_BURST = 2'h2
  } mbp_bus_mode_t;
endpackage : mbp_pkg

// ==== logic/mbp_strobe_if.sv ====
// carries decoded host strobes from the decoder to the bus port logic
// assumes all members are driven on sys_clk
`timescale 1ns/100ps
`default_nettype none
interface mbp_strobe_if;
  logic rdStb;
  logic wrStb;
  logic fetchStb;
  logic active;
  modport src (output rdStb, wrStb, fetchStb, active);
  modport dst (input rdStb, wrStb, fetchStb, active);
endinterface : mbp_strobe_if
`default_nettype wire

// ==== testbench/mbp_bus_port_sva.sv ====
// assertions on the host bus port top pins
// assumes bound into mbp_bus_port with its APD_CYCLES
`timescale 1ns/100ps
`default_nettype none
module mbp_bus_port_sva
#(
  parameter int unsigned APD_CYCLES = 8
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pins
  input wire logic chipSelEn,
  input wire logic chipSel_n,
  input wire logic addrStrobe,
  input wire logic ctl0,
  input wire logic ctl1,
  input wire logic pageWr,
  input wire logic blockSel,
  input wire logic onBattery,
  // outputs
  input wire logic [7:0] lowerAdOe,
  input wire logic [19:0] latchedAddr,
  input wire logic [7:0] pageReg,
  input wire logic [7:0] portEOut,
  input wire logic writeStb,
  input wire logic memEnable,
  input wire logic powerDown,
  input wire logic progAbort
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] idleCnt;
  logic [5:0] asHist;
  logic [5:0] pwHist;
  // ctl2 ignored: the idle count is only an upper bound
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      idleCnt <= 16'h0000;
      asHist <= 6'h00;
      pwHist <= 6'h00;
    end
    else
    begin
      idleCnt <= (addrStrobe || !ctl0 || !ctl1) ? 16'h0000 :
        idleCnt + {15'h0000, idleCnt != 16'hFFFF};
      asHist <= {asHist[4:0], addrStrobe};
      pwHist <= {pwHist[4:0], pageWr};
    end
  ////////////////////////////////////////////////////////////////////////////
  property p_abort;
    @(posedge sys_clk) disable iff (rst_n) progAbort;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort low during reset");
  property p_wstb; writeStb |=> !writeStb; endproperty
  a_wstb: assert property (p_wstb)
    else $error("write strobe longer than one cycle");
  property p_nosel; !blockSel [*4] |-> lowerAdOe == 8'h00; endproperty
  a_nosel: assert property (p_nosel)
    else $error("data driven without a selected block");
  // enable is registered from the previous cycle's memory enable
  property p_oe;
    |lowerAdOe |-> $past(memEnable) && lowerAdOe == 8'hFF;
  endproperty
  a_oe: assert property (p_oe)
    else $error("data driven while memories disabled");
  property p_bat; onBattery [*3] |-> portEOut[7]; endproperty
  a_bat: assert property (p_bat)
    else $error("battery flag low");
  property p_csoff; (chipSelEn && chipSel_n) [*5] |-> !memEnable; endproperty
  a_csoff: assert property (p_csoff)
    else $error("memories on while deselected");
  property p_wake;
    chipSelEn && $rose(chipSel_n) |-> ##[1:4] !powerDown;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on chip select edge");
  property p_apd;
    $rose(powerDown) |-> idleCnt + 16'h0004 >= APD_CYCLES;
  endproperty
  a_apd: assert property (p_apd)
    else $error("power down before idle time");
  property p_latch; !$stable(latchedAddr) |-> |asHist; endproperty
  a_latch: assert property (p_latch)
    else $error("address changed without strobe");
  property p_page; !$stable(pageReg) |-> |{pwHist, pageWr}; endproperty
  a_page: assert property (p_page)
    else $error("page changed without page write");
  cp_read: cover property (lowerAdOe == 8'hFF);
  cp_pd: cover property ($rose(powerDown));
  cp_wstb: cover property (writeStb);
endmodule // mbp_bus_port_sva
`default_nettype wire

// ==== testbench/mbp_host_model.sv ====
// host bus model driving the muxed address/data and control pins
// assumes muxed bus, write strobe and read strobe modes, one clock
`timescale 1ns/100ps
`default_nettype none
module mbp_host_model
(
  // clock
  input wire logic sys_clk,
  // device answer
  input wire logic [7:0] lowerAdOut,
  input wire logic [7:0] lowerAdOe,
  // host pins
  output logic [7:0] lowerAdIn,
  output logic [7:0] upperAdIn,
  output logic [7:0] portFIn,
  output logic addrStrobe,
  output logic ctl0,
  output logic ctl1,
  output logic ctl2
);
  initial {lowerAdIn, upperAdIn, portFIn, addrStrobe, ctl0, ctl1, ctl2}
    = {24'h0, 4'h7};
  ////////////////////////////////////////////////////////////////////////////
  task automatic edges(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // every phase held at least 4 edges, above the 2 the synchroniser needs
  task automatic addr(input logic [19:0] a, input logic chg);
    @(posedge sys_clk);
    {upperAdIn, lowerAdIn, portFIn[3:0]} <= a;
    addrStrobe <= 1'b1;
    edges(4);
    if (chg)
      lowerAdIn <= ~a[11:4];
    edges(chg ? 4 : 0);
    addrStrobe <= 1'b0;
    edges(4);
  endtask
  task automatic wr(input logic [7:0] v);
    @(posedge sys_clk);
    lowerAdIn <= v;
    ctl0 <= 1'b0;
    edges(4);
    ctl0 <= 1'b1;
    edges(4);
  endtask
  task automatic rd(output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge sys_clk);
    // bus released: shows the inverse, never the stale value
    lowerAdIn <= ~lowerAdIn;
    ctl1 <= 1'b0;
    repeat (8)
    begin
      // look mid-cycle, where the registered pins have settled
      @(negedge sys_clk);
      if (!ok && lowerAdOe === 8'hFF)
      begin
        ok = 1'b1;
        d = lowerAdOut;
      end
    end
    @(posedge sys_clk);
    ctl1 <= 1'b1;
    edges(4);
  endtask
endmodule // mbp_host_model
`default_nettype wire

// ==== testbench/test_mbp_bus_port.sv ====
// self-checking bench for the host bus port
// assumes package, strobe interface, design, host model, checker compiled
`timescale 1ns/100ps
`default_nettype none
module test_mbp_bus_port;
  localparam int unsigned AUTO_POWER_DOWN = 8;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b1;
  mbp_pkg::mbp_bus_mode_t busMode;
  mbp_pkg::mbp_ctl0_mode_t ctl0Mode;
  mbp_pkg::mbp_ctl1_mode_t ctl1Mode;
  logic ctl2IsFetch, altStrobeEn, chipSelEn, clkInEn, progPortEn, addrStrobe;
  logic ctl0, ctl1, ctl2, chipSel_n, logicClkIn, pageWr, pwr0Wr, pwr2Wr;
  logic blockSel, progBusy, onBattery, writeStb, memEnable, powerDown;
  logic progAbort, arrayClkEn, arrayHold;
  logic [7:0] portCMode, portCDir, portCOut, lowerAdIn, lowerAdOut, lowerAdOe;
  logic [7:0] upperAdIn, portFIn, portFOut, portFOe, readData, arrayCs;
  logic [7:0] pageReg, writeData, portCIn, portCOutPin, portCOe, portCArrayIn;
  logic [7:0] portEOut, portEOe;
  logic [5:0] serialOut, portEIn, serialIn;
  logic [4:0] arrayCtlIn;
  logic [19:0] latchedAddr;
  int n_fail = 0;
  int compares = 0;
  int nWstb = 0;
  always @(negedge sys_clk) nWstb <= nWstb + int'(writeStb);
  mbp_bus_port #(.APD_CYCLES(AUTO_POWER_DOWN)) mbp_bus_port_i (.*);
  mbp_host_model mbp_host_model_i (.sys_clk, .lowerAdOut, .lowerAdOe,
    .lowerAdIn, .upperAdIn, .portFIn, .addrStrobe, .ctl0, .ctl1, .ctl2);
  always #10 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic s(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_read;
    logic [7:0] d;
    logic ok;
    @(posedge sys_clk)
    begin
      blockSel <= 1'b1;
      readData <= 8'hA5;
    end
    mbp_host_model_i.addr(20'h3C5A0, 1'b0);
    s(0);
    chk(latchedAddr[15:0], 16'h3C5A);
    mbp_host_model_i.rd(d, ok);
    chk(ok, 1'b1);
    chk(d, 8'hA5);
    @(posedge sys_clk) blockSel <= 1'b0;
    mbp_host_model_i.rd(d, ok);
    chk(ok, 1'b0);
  endtask
  task automatic t_write;
    int w0;
    w0 = nWstb;
    @(posedge sys_clk) pageWr <= 1'b1;
    mbp_host_model_i.wr(8'hC3);
    s(0);
    chk(pageReg, 8'hC3);
    chk(writeData, 8'hC3);
    chk(20'(nWstb - w0), 20'h00001);
    @(posedge sys_clk) pageWr <= 1'b0;
  endtask
  task automatic t_burst;
    @(posedge sys_clk)
    begin
      busMode <= mbp_pkg::BUS_BURST;
      altStrobeEn <= 1'b1;
    end
    // low byte moves while strobe high: must keep the rising-edge value
    mbp_host_model_i.addr(20'hA7E39, 1'b1);
    s(0);
    chk(latchedAddr, 20'hA7E39);
    @(posedge sys_clk)
    begin
      busMode <= mbp_pkg::BUS_MUX;
      altStrobeEn <= 1'b0;
    end
  endtask
  task automatic t_block;
    s(0);
    chk(arrayCtlIn[3:1], 3'h7);
    @(posedge sys_clk)
    begin
      pwr2Wr <= 1'b1;
      clkInEn <= 1'b1;
    end
    mbp_host_model_i.wr(8'h3C);
    @(posedge sys_clk) pwr2Wr <= 1'b0;
    s(3);
    chk(arrayCtlIn[3:0], 4'h0);
    chk(arrayClkEn, 1'b1);
    // idle clock pin would freeze the power-down counter later
    @(posedge sys_clk) clkInEn <= 1'b0;
  endtask
  task automatic t_pins;
    @(posedge sys_clk)
    begin
      portCDir <= 8'hFF;
      portCOut <= 8'h96;
      portCIn <= 8'h5A;
      arrayCs <= 8'h3C;
      progPortEn <= 1'b1;
      portEIn <= 6'h05;
      serialOut <= 6'h28;
      onBattery <= 1'b1;
    end
    s(4);
    chk(portCOutPin, 8'h96);
    chk(portCOe, 8'hFF);
    chk(serialIn[2:0], 3'h5);
    chk(portEOut[5:3], 3'h5);
    chk(portEOut[7], 1'b1);
    chk(portEOe, 8'hB8);
  endtask
  task automatic t_cs;
    @(posedge sys_clk)
    begin
      chipSelEn <= 1'b1;
      chipSel_n <= 1'b1;
    end
    s(5);
    chk(memEnable, 1'b0);
    @(posedge sys_clk) chipSel_n <= 1'b0;
    s(5);
    chk(memEnable, 1'b1);
  endtask
  task automatic t_apd;
    @(posedge sys_clk) pwr0Wr <= 1'b1;
    // auto power-down on, turbo off
    mbp_host_model_i.wr(8'h0A);
    @(posedge sys_clk) pwr0Wr <= 1'b0;
    s(AUTO_POWER_DOWN + 6);
    chk(powerDown, 1'b1);
    chk(arrayHold, 1'b1);
    @(posedge sys_clk) chipSel_n <= 1'b1;
    s(3);
    chk(powerDown, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    busMode = mbp_pkg::BUS_MUX;
    ctl0Mode = mbp_pkg::CTL0_WRITE_N;
    ctl1Mode = mbp_pkg::CTL1_READ_N;
    {ctl2IsFetch, altStrobeEn, chipSelEn, clkInEn, progPortEn, chipSel_n,
      logicClkIn, pageWr, pwr0Wr, pwr2Wr, blockSel, onBattery} = '0;
    {portCMode, portCDir, portCOut, readData, arrayCs, portCIn} = '0;
    {serialOut, portEIn} = '0;
    progBusy = 1'b1;
    // a real falling edge, so the asynchronous reset acts at once
    #5 rst_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk(progAbort, 1'b1);
    chk(lowerAdOe, 8'h00);
    chk(pageReg, mbp_pkg::PAGE_RST);
    @(posedge sys_clk)
    begin
      rst_n <= 1'b1;
      progBusy <= 1'b0;
    end
    s(3);
    t_read;
    t_write;
    t_burst;
    t_block;
    t_pins;
    t_cs;
    t_apd;
    print_verdict;
  end
endmodule // test_mbp_bus_port
bind mbp_bus_port mbp_bus_port_sva #(.APD_CYCLES(APD_CYCLES)) sva_i (.sys_clk,
  .rst_n, .chipSelEn, .chipSel_n, .addrStrobe, .ctl0, .ctl1, .pageWr,
  .blockSel, .onBattery, .lowerAdOe, .latchedAddr, .pageReg, .portEOut,
  .writeStb, .memEnable, .powerDown, .progAbort);
`default_nettype wire
